// ===== rtl/dhp_pkg.sv
// constants, register map and state type of the dma handshake port
package dhp_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam int CNT_W  = 16;
  localparam int WS_W   = 3;

  // register byte offsets
  localparam logic [4:0] OFF_CTRL   = 5'h00;
  localparam logic [4:0] OFF_WAIT   = 5'h04;
  localparam logic [4:0] OFF_ADDR   = 5'h08;
  localparam logic [4:0] OFF_COUNT  = 5'h0c;
  localparam logic [4:0] OFF_STATUS = 5'h10;
  localparam logic [4:0] OFF_WDATA  = 5'h14;
  localparam logic [4:0] OFF_RDATA  = 5'h18;

  // field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_DIR_BIT  = 3;
  localparam int WAIT_WS_LSB   = 0;
  localparam int WAIT_HI_BIT   = 3;
  localparam int MS_BANK_LSB   = 26;
  localparam int PAGE_LSB      = 8;

  // reset values
  localparam logic [3:0]        CTRL_RST  = 4'h0;
  localparam logic [3:0]        WAIT_RST  = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 32'h0000_0000;
  localparam logic [CNT_W-1:0]  COUNT_RST = 16'h0000;

  // handshake modes
  localparam logic [1:0] MODE_HS    = 2'h0;
  localparam logic [1:0] MODE_EXT   = 2'h1;
  localparam logic [1:0] MODE_PACED = 2'h2;

  // timing: clock period and the one-cycle gap for hold or idle cycles
  localparam int CLK_PERIOD_NS = 8;
  localparam int HI_NS         = 8;
  localparam int HI_CYC        = (HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_STROBE = 3'b010,
    ST_WREND  = 3'b011,
    ST_GAP    = 3'b100
  } dhp_state_t;
endpackage

// ===== rtl/dhp_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module dhp_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= RST;
      q      <= RST;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/dhp_buf2.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module dhp_buf2 #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  logic [W-1:0] mem_r [2];
  logic         rd_ptr_r;
  logic         wr_ptr_r;
  logic [1:0]   cnt_r;
  wire          push = in_valid & in_ready;
  wire          pop  = out_valid & out_ready;

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rd_ptr_r];

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_ptr_r <= 1'b0;
      wr_ptr_r <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/dhp_top.sv
// dma handshake port: request/grant engine with avalon-mm register slave
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module dhp_top (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        dma_request_n,
  output logic             dma_grant_n,
  output logic      [31:0] addr_o,
  output logic             rd_n,
  output logic             wr_n,
  output logic             sync_write_select_n,
  output logic             page,
  output logic      [3:0]  memory_select_n,
  input  wire logic        ack,
  input  wire logic [31:0] data_i,
  output logic      [31:0] data_o,
  output logic             data_oe
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  localparam int DW = dhp_pkg::DATA_W;
  localparam int CW = dhp_pkg::CNT_W;
  localparam int WW = dhp_pkg::WS_W;

  dhp_pkg::dhp_state_t st_r;
  dhp_pkg::dhp_state_t st_nxt;
  logic [3:0]    ctrl_r;
  logic [3:0]    wait_r;
  logic [31:0]   base_r;
  logic [CW-1:0] count_r;
  logic [DW-1:0] wdata_r;
  logic          wfull_r;
  logic [WW-1:0] ws_cnt_r;
  logic [31:0]   xaddr_r;
  logic [31:0]   last_addr_r;
  logic          req_n_s;
  logic          ack_s;
  logic [DW-1:0] data_s;
  logic          buf_in_ready;
  logic          buf_out_valid;
  logic [DW-1:0] buf_out_data;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  dhp_sync #(.W(1), .RST(1'b1)) u_req_sync (
    .clk   (clk),
    .reset (reset),
    .d     (dma_request_n),
    .q     (req_n_s)
  );

  dhp_sync #(.W(1), .RST(1'b0)) u_ack_sync (
    .clk   (clk),
    .reset (reset),
    .d     (ack),
    .q     (ack_s)
  );

  dhp_sync #(.W(DW), .RST('0)) u_data_sync (
    .clk   (clk),
    .reset (reset),
    .d     (data_i),
    .q     (data_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode of control fields and transfer conditions
  wire [1:0]    mode      = ctrl_r[dhp_pkg::CTRL_MODE_LSB +: 2];
  wire          enabled   = ctrl_r[dhp_pkg::CTRL_EN_BIT];
  wire          dir_wr    = ctrl_r[dhp_pkg::CTRL_DIR_BIT];
  wire [WW-1:0] ws_cfg    = wait_r[dhp_pkg::WAIT_WS_LSB +: WW];
  wire          hi_cfg    = wait_r[dhp_pkg::WAIT_HI_BIT];
  wire          mode_ok   = (mode == dhp_pkg::MODE_HS) | (mode == dhp_pkg::MODE_EXT) |
                            (mode == dhp_pkg::MODE_PACED);
  wire          is_paced  = (mode == dhp_pkg::MODE_PACED);
  wire          is_ext    = (mode == dhp_pkg::MODE_EXT);
  wire          use_bus   = is_ext | is_paced;
  wire          data_rdy  = dir_wr ? wfull_r : buf_in_ready;
  wire          start     = enabled & mode_ok & (count_r != '0) & ~req_n_s & data_rdy;
  wire          held      = is_paced ? ~ack_s : ~req_n_s;
  wire          done      = (st_r == dhp_pkg::ST_STROBE) & (ws_cnt_r == '0) & ~held;
  wire          capture   = done & ~dir_wr;
  wire [1:0]    bank      = base_r[dhp_pkg::MS_BANK_LSB +: 2];
  wire          new_page  = base_r[31:dhp_pkg::PAGE_LSB] != last_addr_r[31:dhp_pkg::PAGE_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // transfer state machine
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      dhp_pkg::ST_IDLE: begin
        if (start) begin
          st_nxt = dhp_pkg::ST_SETUP;
        end
      end
      dhp_pkg::ST_SETUP: begin
        st_nxt = dhp_pkg::ST_STROBE;
      end
      dhp_pkg::ST_STROBE: begin
        if (done && dir_wr) begin
          st_nxt = dhp_pkg::ST_WREND;
        end else if (done) begin
          st_nxt = hi_cfg ? dhp_pkg::ST_GAP : dhp_pkg::ST_IDLE;
        end
      end
      dhp_pkg::ST_WREND: begin
        st_nxt = hi_cfg ? dhp_pkg::ST_GAP : dhp_pkg::ST_IDLE;
      end
      dhp_pkg::ST_GAP: begin
        st_nxt = dhp_pkg::ST_IDLE;
      end
      default: begin
        st_nxt = dhp_pkg::ST_IDLE;
      end
    endcase
  end

  // next values of the pin outputs, all taken from the next state
  wire nx_strobe = (st_nxt == dhp_pkg::ST_STROBE);
  wire nx_hold   = nx_strobe | (st_nxt == dhp_pkg::ST_WREND);
  wire nx_xfer   = nx_hold | (st_nxt == dhp_pkg::ST_SETUP);
  wire grant_nxt = ~(nx_hold & ~is_paced);
  wire rd_nxt    = ~(nx_strobe & ~dir_wr & use_bus);
  wire wr_nxt    = ~(nx_strobe & dir_wr & use_bus);
  wire sw_nxt    = ~(nx_strobe & dir_wr & is_ext);
  wire [3:0] ms_nxt = (nx_xfer & use_bus) ? ~(4'h1 << bank) : 4'hf;

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= dhp_pkg::ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dma_grant_n         <= 1'b1;
      rd_n                <= 1'b1;
      wr_n                <= 1'b1;
      sync_write_select_n <= 1'b1;
      memory_select_n     <= 4'hf;
      data_oe             <= 1'b0;
    end else begin
      dma_grant_n         <= grant_nxt;
      rd_n                <= rd_nxt;
      wr_n                <= wr_nxt;
      sync_write_select_n <= sw_nxt;
      memory_select_n     <= ms_nxt;
      data_oe             <= nx_xfer & dir_wr;
    end
  end

  // address, page and data latched at setup and held through the transfer
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_o      <= dhp_pkg::ADDR_RST;
      last_addr_r <= dhp_pkg::ADDR_RST;
      page        <= 1'b0;
      data_o      <= '0;
    end else if (st_nxt == dhp_pkg::ST_SETUP) begin
      addr_o      <= base_r;
      last_addr_r <= base_r;
      page        <= use_bus & new_page;
      data_o      <= wdata_r;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ws_cnt_r <= '0;
    end else if (st_r == dhp_pkg::ST_SETUP) begin
      ws_cnt_r <= ws_cfg;
    end else if (st_r == dhp_pkg::ST_STROBE && ws_cnt_r != '0) begin
      ws_cnt_r <= ws_cnt_r - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data buffer
  wire rdata_pop;

  dhp_buf2 #(.W(DW)) u_rbuf (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (capture),
    .in_ready  (buf_in_ready),
    .in_data   (data_s),
    .out_valid (buf_out_valid),
    .out_ready (rdata_pop),
    .out_data  (buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // avalon-mm slave
  wire        bus_req   = read | write;
  wire        sel_ctrl  = (address == dhp_pkg::OFF_CTRL);
  wire        sel_wait  = (address == dhp_pkg::OFF_WAIT);
  wire        sel_addr  = (address == dhp_pkg::OFF_ADDR);
  wire        sel_count = (address == dhp_pkg::OFF_COUNT);
  wire        sel_stat  = (address == dhp_pkg::OFF_STATUS);
  wire        sel_wdata = (address == dhp_pkg::OFF_WDATA);
  wire        sel_rdata = (address == dhp_pkg::OFF_RDATA);
  wire        accept    = ~(write & sel_wdata & wfull_r);
  wire        fire      = bus_req & ~waitrequest;
  wire        wfire     = fire & write;
  wire [31:0] bemask    = {{8{byteenable[3]}}, {8{byteenable[2]}},
                           {8{byteenable[1]}}, {8{byteenable[0]}}};
  wire [31:0] status_w  = {13'h0, st_r, 12'h0, ~req_n_s, buf_out_valid, wfull_r,
                           st_r != dhp_pkg::ST_IDLE};
  wire [31:0] rd_mux    = sel_ctrl  ? {28'h0, ctrl_r} :
                          sel_wait  ? {28'h0, wait_r} :
                          sel_addr  ? base_r :
                          sel_count ? {16'h0, count_r} :
                          sel_stat  ? status_w :
                          sel_wdata ? wdata_r :
                          (sel_rdata & buf_out_valid) ? buf_out_data : 32'h0;

  assign rdata_pop = fire & read & sel_rdata;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  wire [31:0] ctrl_w  = merge({28'h0, ctrl_r}, writedata, bemask);
  wire [31:0] wait_w  = merge({28'h0, wait_r}, writedata, bemask);
  wire [31:0] count_w = merge({16'h0, count_r}, writedata, bemask);

  always_ff @(posedge clk) begin
    if (reset) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0;
    end else begin
      waitrequest <= ~(waitrequest & bus_req & accept);
      if (waitrequest && read) begin
        readdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= dhp_pkg::CTRL_RST;
      wait_r <= dhp_pkg::WAIT_RST;
    end else if (wfire) begin
      if (sel_ctrl) begin
        ctrl_r <= ctrl_w[3:0];
      end
      if (sel_wait) begin
        wait_r <= wait_w[3:0];
      end
    end
  end

  // software writes win over the per-transfer step
  always_ff @(posedge clk) begin
    if (reset) begin
      base_r  <= dhp_pkg::ADDR_RST;
      count_r <= dhp_pkg::COUNT_RST;
    end else begin
      if (wfire && sel_addr) begin
        base_r <= merge(base_r, writedata, bemask);
      end else if (done) begin
        base_r <= base_r + 32'h1;
      end
      if (wfire && sel_count) begin
        count_r <= count_w[CW-1:0];
      end else if (done) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  // write word holder; a new word is only accepted once the last one went out
  always_ff @(posedge clk) begin
    if (reset) begin
      wdata_r <= '0;
      wfull_r <= 1'b0;
    end else if (wfire && sel_wdata) begin
      wdata_r <= merge(wdata_r, writedata, bemask);
      wfull_r <= 1'b1;
    end else if (done && dir_wr) begin
      wfull_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_MODE_ONLY_THREE: assert property (
    (st_r == dhp_pkg::ST_IDLE) && (mode == 2'h3) |=> (st_r == dhp_pkg::ST_IDLE))
    else $error("transfer started in an undefined mode");

  AST_START_ON_REQUEST: assert property (
    (st_r == dhp_pkg::ST_SETUP) |-> ~$past(req_n_s))
    else $error("transfer began without a request");

  AST_PACED_NO_GRANT: assert property (
    is_paced && $stable(ctrl_r) && (st_r != dhp_pkg::ST_IDLE) |-> dma_grant_n)
    else $error("grant asserted in paced master mode");

  AST_WAIT_STATES: assert property (
    $fell(dma_grant_n) && (ws_cfg == 3'h3) && $stable(wait_r) |-> (~dma_grant_n)[*4])
    else $error("grant shorter than programmed wait states");

  AST_WAIT_EXTEND: assert property (
    (st_r == dhp_pkg::ST_STROBE) && (ws_cnt_r != '0) |=> (st_r == dhp_pkg::ST_STROBE))
    else $error("strobe ended before the wait states ran out");

  AST_HOLD_GAP: assert property (
    $rose(dma_grant_n) && hi_cfg |-> dma_grant_n[*3])
    else $error("no extra clock after grant release");

  AST_READ_PROLONG: assert property (
    (st_r == dhp_pkg::ST_STROBE) && (ws_cnt_r == '0) && ~req_n_s && ~is_paced
      |=> (st_r == dhp_pkg::ST_STROBE) && ~dma_grant_n)
    else $error("read ended while request held low");

  AST_GRANT_CLOCKED: assert property (
    $changed(dma_grant_n) |-> $changed(st_r))
    else $error("grant changed without a state change");

  AST_WR_LOW_WITH_GRANT: assert property (
    $fell(dma_grant_n) && is_ext && dir_wr |-> ~wr_n)
    else $error("write strobe not low with grant");

  AST_WR_HIGH_FIRST: assert property (
    $rose(wr_n) && is_ext |-> ~dma_grant_n ##1 dma_grant_n)
    else $error("write strobe not released one clock before grant");

  AST_RD_BY_RELEASE: assert property (
    $rose(dma_grant_n) && is_ext && ~dir_wr |-> rd_n && !$past(rd_n))
    else $error("read strobe not released with grant");

  AST_ADDR_STABLE: assert property (
    ~dma_grant_n && ~$fell(dma_grant_n) |-> $stable(addr_o) && $stable(memory_select_n))
    else $error("address or select moved while granted");

  AST_GRANT_IDLE_HIGH: assert property (
    (st_r == dhp_pkg::ST_IDLE) || (st_r == dhp_pkg::ST_SETUP) || (st_r == dhp_pkg::ST_GAP)
      |-> dma_grant_n)
    else $error("grant low outside a transfer");
endmodule
`default_nettype wire

// ===== tb/dhp_periph.sv
// far-side peripheral model: request, hold-off, pacing ack and read data
`timescale 1ns/100ps
`default_nettype none
module dhp_periph #(
  parameter logic [31:0] BASE = 32'h5a3c_0000
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        req_en,
  input  wire logic [1:0]  hold,
  input  wire logic        paced,
  input  wire logic        dma_grant_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  output logic             dma_request_n,
  output logic             ack,
  output logic      [31:0] data_i
);
  logic        req_r  = 1'b1;
  logic        ack_r  = 1'b0;
  logic        rest_r = 1'b0;
  logic [1:0]  cnt_r  = 2'h0;
  logic [31:0] n_r    = 32'h0;
  wire         act    = !dma_grant_n || !rd_n || !wr_n;
  assign dma_request_n = req_r;
  assign ack           = ack_r;
  // word shown while asking or granted, inverted once released
  assign data_i = (act || !req_r) ? BASE + n_r : ~(BASE + n_r);
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (reset) begin
      req_r  <= 1'b1;
      ack_r  <= 1'b0;
      rest_r <= 1'b0;
      cnt_r  <= 2'h0;
      n_r    <= 32'h0;
    end else if (act) begin
      rest_r <= 1'b1;
      ack_r  <= paced && cnt_r == hold;
      // keep asking for hold cycles to stretch the access
      if (cnt_r != hold) begin
        cnt_r <= cnt_r + 2'h1;
      end else begin
        req_r <= 1'b1;
      end
    end else if (rest_r) begin
      rest_r <= 1'b0;
      ack_r  <= 1'b0;
      cnt_r  <= 2'h0;
      n_r    <= n_r + 32'h1;
    end else begin
      req_r <= !req_en;
    end
  end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench: registers, every mode and direction, buffer stall
`timescale 1ns/100ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] d;
  } dhp_exp_t;
  localparam logic [31:0] BASE = 32'h5a3c_0000;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [4:0]  address = 5'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic        req_en = 1'b0;
  logic [1:0]  hold = 2'h0;
  logic [1:0]  md = 2'h0;
  logic        dir = 1'b0;
  logic        hi = 1'b0;
  logic [2:0]  ws = 3'h0;
  logic [31:0] lp = 32'h0;
  logic        pa = 1'b0, pg = 1'b1, pw = 1'b1, ps = 1'b0;
  logic [31:0] readdata, addr_o, data_i, data_o, wd, sa;
  logic [3:0]  memory_select_n, sm;
  logic        waitrequest, dma_request_n, dma_grant_n, rd_n, wr_n;
  logic        sync_write_select_n, page, data_oe, ack;
  int          failures, total_checks, xfers, tb_n, minw, gl, sl;
  int          gh = 99;
  dhp_exp_t    exp_x[$];
  dhp_exp_t    cur;
  logic [31:0] exp_rd[$];
  wire         act = !dma_grant_n || !rd_n || !wr_n;
  wire         strobe = !rd_n || !wr_n;
  always #(dhp_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
  dhp_top dut (
    .clk                 (clk),
    .reset               (reset),
    .address             (address),
    .read                (read),
    .write               (write),
    .writedata           (writedata),
    .byteenable          (4'hf),
    .readdata            (readdata),
    .waitrequest         (waitrequest),
    .dma_request_n       (dma_request_n),
    .dma_grant_n         (dma_grant_n),
    .addr_o              (addr_o),
    .rd_n                (rd_n),
    .wr_n                (wr_n),
    .sync_write_select_n (sync_write_select_n),
    .page                (page),
    .memory_select_n     (memory_select_n),
    .ack                 (ack),
    .data_i              (data_i),
    .data_o              (data_o),
    .data_oe             (data_oe)
  );
  dhp_periph #(.BASE(BASE)) peer (
    .clk           (clk),
    .reset         (reset),
    .req_en        (req_en),
    .hold          (hold),
    .paced         (md == dhp_pkg::MODE_PACED),
    .dma_grant_n   (dma_grant_n),
    .rd_n          (rd_n),
    .wr_n          (wr_n),
    .dma_request_n (dma_request_n),
    .ack           (ack),
    .data_i        (data_i)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= d;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 300);
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      chk("waitrequest", 32'h0, {31'h0, waitrequest});
      stop_test();
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wait_x(input int n);
    int k;
    k = 0;
    while (xfers < n && k < 2000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 2000) begin
      chk("transfer count", 32'(n), 32'(xfers));
      stop_test();
    end
  endtask
  // one mode and direction with random wait (3 for external-bus reads), hold-off and hold/idle setting
  task automatic run(input logic [1:0] m, input logic d);
    logic [31:0] a;
    logic [1:0]  h;
    int          c;
    int          i0;
    md = m;
    dir = d;
    ws = (m == dhp_pkg::MODE_EXT && !d) ? 3'h3 : 3'($urandom_range(7));
    hi = 1'($urandom_range(1));
    h = 2'($urandom_range(3));
    hold <= h;
    minw = ((ws > h) ? int'(ws) : int'(h)) + 1;
    a = $urandom & 32'h0c00_0ff0;
    c = d ? 2 : 3;
    i0 = tb_n;
    for (int j = 0; j < c; j++) exp_x.push_back({a + 32'(j), 32'hc0de_0000 + 32'(i0 + j)});
    bus(1'b1, dhp_pkg::OFF_WAIT, {28'h0, hi, ws});
    bus(1'b1, dhp_pkg::OFF_ADDR, a);
    bus(1'b1, dhp_pkg::OFF_COUNT, 32'(c));
    bus(1'b1, dhp_pkg::OFF_CTRL, {28'h0, d, m, 1'b1});
    req_en <= 1'b1;
    if (d) for (int j = 0; j < c; j++) bus(1'b1, dhp_pkg::OFF_WDATA, 32'hc0de_0000 + 32'(i0 + j));
    wait_x(i0 + 2);
    if (!d) begin
      // receiver stalls: the third word waits for buffer space
      repeat (30) @(posedge clk);
      chk("buffer stall", 32'(i0 + 2), 32'(xfers));
      for (int j = 0; j < 3; j++) begin
        rd(dhp_pkg::OFF_RDATA, BASE + 32'(i0 + j));
        if (j == 0) wait_x(i0 + 3);
      end
    end
    req_en <= 1'b0;
    tb_n = i0 + c;
    rd(dhp_pkg::OFF_ADDR, a + 32'(c));
    rd(dhp_pkg::OFF_COUNT, 32'h0);
    bus(1'b1, dhp_pkg::OFF_CTRL, 32'h0);
    repeat (4) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (!reset) begin
      if (read && waitrequest === 1'b0) chk("readdata", exp_rd.pop_front(), readdata);
      if (act && !pa) begin
        if (exp_x.size() == 0) chk("spurious transfer", 32'h0, 32'h1);
        else cur = exp_x.pop_front();
        sa = addr_o;
        sm = memory_select_n;
        if (md != dhp_pkg::MODE_HS) begin
          chk("addr_o", cur.a, addr_o);
          chk("memory_select_n", {28'h0, ~(4'h1 << cur.a[27:26])}, {28'h0, memory_select_n});
          chk("page", {31'h0, cur.a[31:8] != lp[31:8]}, {31'h0, page});
        end
        lp = cur.a;
      end
      if (act) chk("data_oe", {31'h0, dir}, {31'h0, data_oe});
      if (act && pa && md != dhp_pkg::MODE_HS) chk("addr hold", 32'h1, 32'(addr_o === sa && memory_select_n === sm));
      if (act && md == dhp_pkg::MODE_HS) chk("hs strobes", 32'h1, 32'(rd_n && wr_n && memory_select_n === 4'hf));
      if (md == dhp_pkg::MODE_PACED) chk("paced grant", 32'h1, {31'h0, dma_grant_n});
      if (md == dhp_pkg::MODE_EXT && !wr_n) chk("sync write", 32'h0, {31'h0, sync_write_select_n});
      if (!wr_n || (md == dhp_pkg::MODE_HS && !dma_grant_n)) wd = data_o;
      if (dma_grant_n && !pg) begin
        chk("grant width", 32'h1, 32'(gl >= minw));
        if (md == dhp_pkg::MODE_EXT) chk("strobe release", 32'h1, {31'h0, dir ? pw : rd_n});
      end
      if (!dma_grant_n && pg) chk("grant gap", 32'h1, 32'(gh >= (hi ? 3 : 2)));
      if (!strobe && ps) chk("strobe width", 32'h1, 32'(sl >= minw));
      if (!act && pa) begin
        xfers++;
        if (dir) chk("data_o", cur.d, wd);
      end
      gl = dma_grant_n ? 0 : gl + 1;
      gh = dma_grant_n ? gh + 1 : 0;
      sl = strobe ? sl + 1 : 0;
      pa = act;
      pg = dma_grant_n;
      pw = wr_n;
      ps = strobe;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h96f08ae4));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rd(dhp_pkg::OFF_CTRL, {28'h0, dhp_pkg::CTRL_RST});
    rd(dhp_pkg::OFF_WAIT, {28'h0, dhp_pkg::WAIT_RST});
    rd(dhp_pkg::OFF_ADDR, dhp_pkg::ADDR_RST);
    rd(dhp_pkg::OFF_COUNT, {16'h0, dhp_pkg::COUNT_RST});
    bus(1'b1, 5'h1c, 32'hffff_ffff);
    rd(5'h1c, 32'h0);
    // undefined mode with a request, then a valid mode without one
    bus(1'b1, dhp_pkg::OFF_COUNT, 32'h1);
    bus(1'b1, dhp_pkg::OFF_CTRL, 32'h7);
    req_en <= 1'b1;
    repeat (40) @(posedge clk);
    chk("mode 3 idle", 32'h0, 32'(xfers));
    req_en <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b1, dhp_pkg::OFF_CTRL, 32'h3);
    repeat (40) @(posedge clk);
    chk("no request idle", 32'h1, {31'h0, dma_grant_n});
    bus(1'b1, dhp_pkg::OFF_CTRL, 32'h0);
    for (int m = 0; m < 3; m++) begin
      for (int d = 0; d < 2; d++) run(2'(m), 1'(d));
    end
    stop_test();
  end
endmodule
`default_nettype wire
